// ---- rtl/ipsm_input_route.sv ----
/*
  Input routing multiplexer top: two selector registers on a plain register port and three
  routed peripheral inputs (external interrupt one, encoder phases A and B).
  Assumes a register master that issues single-cycle strobes synchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipsm_regs.svh"

module ipsm_input_route #(
  parameter int NUM_PINS = 128
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [NUM_PINS-1:0] remappable_pin_i,
  input wire logic comparator_one_output_i,
  output logic external_interrupt_one_o,
  output logic encoder_phase_a_o,
  output logic encoder_phase_b_o
);

  if (NUM_PINS != 128)
  begin : g_bad_pins
    $error("NUM_PINS must be 128 to cover every seven-bit code.");
  end

  ipsm_pkg::ipsm_bus_req_t req;
  ipsm_pkg::ipsm_routed_t routed;
  logic [`IPSM_SEL_W-1:0] ext_irq_one_source_sel_q;
  logic [`IPSM_SEL_W-1:0] encoder_phase_a_source_sel_q;
  logic [`IPSM_SEL_W-1:0] encoder_phase_b_source_sel_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] rdata_d;

  assign req = '{
    addr: reg_addr_i,
    wdata: reg_wdata_i,
    wr: reg_wr_i,
    rd: reg_rd_i
  };

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Interrupt selector lives in bits 14..8; other bits are not stored.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_irq_one_source_sel_q <= `IPSM_SEL_RESET;
    end
    else if (req.wr && hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE))
    begin
      ext_irq_one_source_sel_q <= req.wdata[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB];
    end
  end

  // Encoder selectors: phase B high field, phase A low field.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      encoder_phase_a_source_sel_q <= `IPSM_SEL_RESET;
      encoder_phase_b_source_sel_q <= `IPSM_SEL_RESET;
    end
    else if (req.wr && hit(req.addr, `IPSM_OFS_ENC_ROUTE))
    begin
      encoder_phase_b_source_sel_q <= req.wdata[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB];
      encoder_phase_a_source_sel_q <= req.wdata[`IPSM_LO_FIELD_MSB:`IPSM_LO_FIELD_LSB];
    end
  end

  // Read data: unimplemented bits read zero, unmapped addresses read zero.
  always_comb
  begin
    rdata_d = 16'h0000;
    if (hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE))
    begin
      rdata_d[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB] = ext_irq_one_source_sel_q;
    end
    else if (hit(req.addr, `IPSM_OFS_ENC_ROUTE))
    begin
      rdata_d[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB] = encoder_phase_b_source_sel_q;
      rdata_d[`IPSM_LO_FIELD_MSB:`IPSM_LO_FIELD_LSB] = encoder_phase_a_source_sel_q;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_q <= 16'h0000;
    end
    else if (req.rd)
    begin
      reg_rdata_q <= rdata_d;
    end
    else
    begin
      reg_rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o = reg_rdata_q;

  ipsm_source_mux #(.NUM_PINS(NUM_PINS)) u_mux_irq (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(ext_irq_one_source_sel_q),
    .remappable_pin_i(remappable_pin_i),
    .comparator_one_output_i(comparator_one_output_i),
    .routed_o(routed.ext_irq_one)
  );

  ipsm_source_mux #(.NUM_PINS(NUM_PINS)) u_mux_enc_a (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(encoder_phase_a_source_sel_q),
    .remappable_pin_i(remappable_pin_i),
    .comparator_one_output_i(comparator_one_output_i),
    .routed_o(routed.enc_phase_a)
  );

  ipsm_source_mux #(.NUM_PINS(NUM_PINS)) u_mux_enc_b (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(encoder_phase_b_source_sel_q),
    .remappable_pin_i(remappable_pin_i),
    .comparator_one_output_i(comparator_one_output_i),
    .routed_o(routed.enc_phase_b)
  );

  assign external_interrupt_one_o = routed.ext_irq_one;
  assign encoder_phase_a_o = routed.enc_phase_a;
  assign encoder_phase_b_o = routed.enc_phase_b;

  sequence s_irq_write;
    req.wr && hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE);
  endsequence

  sequence s_enc_write;
    req.wr && hit(req.addr, `IPSM_OFS_ENC_ROUTE);
  endsequence

  sequence s_irq_read;
    req.rd && hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE);
  endsequence

  sequence s_enc_read;
    req.rd && hit(req.addr, `IPSM_OFS_ENC_ROUTE);
  endsequence

  sequence s_unmapped_read;
    req.rd && !hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE) && !hit(req.addr, `IPSM_OFS_ENC_ROUTE);
  endsequence

  AST_IRQ_FIELD_STORED: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_irq_write |=> ext_irq_one_source_sel_q == $past(req.wdata[14:8]))
    else $error("Interrupt selector did not take bits 14 to 8.");

  AST_PIN_HI_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    ext_irq_one_source_sel_q == `IPSM_CODE_PIN_HI
    |=> external_interrupt_one_o == $past(remappable_pin_i[`IPSM_PIN_HI_INDEX]))
    else $error("Code 1111001 did not route pin 121.");

  AST_CMP_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_a_source_sel_q == `IPSM_CODE_COMPARATOR_ONE
    |=> encoder_phase_a_o == $past(comparator_one_output_i))
    else $error("Code one did not route the comparator.");

  AST_GROUND_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_b_source_sel_q == `IPSM_CODE_GROUND |=> !encoder_phase_b_o)
    else $error("Code zero did not ground the input.");

  AST_IRQ_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
    req.rd && hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE)
    |=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[7:0] == 8'h00)
    else $error("Unimplemented interrupt register bits read nonzero.");

  AST_ENC_READBACK: assert property (@(posedge mclk_i) disable iff (reset_i)
    req.rd && hit(req.addr, `IPSM_OFS_ENC_ROUTE)
    |=> reg_rdata_o == {1'b0, encoder_phase_b_source_sel_q, 1'b0, encoder_phase_a_source_sel_q})
    else $error("Encoder register read back wrong.");

  AST_NEW_SEL_TIMING: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_irq_write ##1 (ext_irq_one_source_sel_q == `IPSM_CODE_GROUND)
    |=> !external_interrupt_one_o)
    else $error("Grounding write did not act the next cycle.");

  AST_RDATA_ONE_CYCLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !req.rd |=> reg_rdata_o == 16'h0000)
    else $error("Read data stood outside the read answer cycle.");

  AST_IRQ_READBACK: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_irq_read
    |=> reg_rdata_o[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB] == $past(ext_irq_one_source_sel_q))
    else $error("Interrupt selector read back wrong.");

  AST_IRQ_HELD: assert property (@(posedge mclk_i) disable iff (reset_i)
    !(req.wr && hit(req.addr, `IPSM_OFS_EXT_IRQ_ROUTE))
    |=> $stable(ext_irq_one_source_sel_q))
    else $error("Interrupt selector changed without a write.");

  AST_ENC_B_STORED: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_write
    |=> encoder_phase_b_source_sel_q == $past(req.wdata[`IPSM_HI_FIELD_MSB:`IPSM_HI_FIELD_LSB]))
    else $error("Encoder phase B selector did not take bits 14 to 8.");

  AST_ENC_A_STORED: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_write
    |=> encoder_phase_a_source_sel_q == $past(req.wdata[`IPSM_LO_FIELD_MSB:`IPSM_LO_FIELD_LSB]))
    else $error("Encoder phase A selector did not take bits 6 to 0.");

  AST_ENC_HELD: assert property (@(posedge mclk_i) disable iff (reset_i)
    !(req.wr && hit(req.addr, `IPSM_OFS_ENC_ROUTE))
    |=> $stable(encoder_phase_a_source_sel_q) && $stable(encoder_phase_b_source_sel_q))
    else $error("Encoder selectors changed without a write.");

  AST_ENC_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_read
    |=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[7] == 1'b0)
    else $error("Unimplemented encoder register bits read nonzero.");

  AST_ENC_A_PIN_HI_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_a_source_sel_q == `IPSM_CODE_PIN_HI
    |=> encoder_phase_a_o == $past(remappable_pin_i[`IPSM_PIN_HI_INDEX]))
    else $error("Code 1111001 did not route pin 121 to phase A.");

  AST_ENC_B_PIN_HI_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_b_source_sel_q == `IPSM_CODE_PIN_HI
    |=> encoder_phase_b_o == $past(remappable_pin_i[`IPSM_PIN_HI_INDEX]))
    else $error("Code 1111001 did not route pin 121 to phase B.");

  AST_IRQ_CMP_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    ext_irq_one_source_sel_q == `IPSM_CODE_COMPARATOR_ONE
    |=> external_interrupt_one_o == $past(comparator_one_output_i))
    else $error("Code one did not route the comparator to the interrupt.");

  AST_ENC_B_CMP_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_b_source_sel_q == `IPSM_CODE_COMPARATOR_ONE
    |=> encoder_phase_b_o == $past(comparator_one_output_i))
    else $error("Code one did not route the comparator to phase B.");

  AST_IRQ_GROUND_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    ext_irq_one_source_sel_q == `IPSM_CODE_GROUND
    |=> !external_interrupt_one_o)
    else $error("Code zero did not ground the interrupt input.");

  AST_ENC_A_GROUND_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    encoder_phase_a_source_sel_q == `IPSM_CODE_GROUND
    |=> !encoder_phase_a_o)
    else $error("Code zero did not ground phase A.");

  AST_SEL_RESET_VALUE: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(reset_i)
    |-> ext_irq_one_source_sel_q == `IPSM_SEL_RESET
      && encoder_phase_a_source_sel_q == `IPSM_SEL_RESET
      && encoder_phase_b_source_sel_q == `IPSM_SEL_RESET)
    else $error("Selectors did not start at zero after reset.");

  AST_OUT_RESET_VALUE: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(reset_i)
    |-> !external_interrupt_one_o && !encoder_phase_a_o && !encoder_phase_b_o)
    else $error("Routed inputs did not start grounded after reset.");

  AST_IRQ_WRITE_KEEPS_ENC: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_irq_write
    |=> $stable(encoder_phase_a_source_sel_q) && $stable(encoder_phase_b_source_sel_q))
    else $error("Interrupt register write disturbed the encoder selectors.");

  AST_ENC_WRITE_KEEPS_IRQ: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_write
    |=> $stable(ext_irq_one_source_sel_q))
    else $error("Encoder register write disturbed the interrupt selector.");

  AST_NEW_SEL_ENC_A_TIMING: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_write ##1 (encoder_phase_a_source_sel_q == `IPSM_CODE_COMPARATOR_ONE)
    |=> encoder_phase_a_o == $past(comparator_one_output_i))
    else $error("Phase A comparator write did not act the next cycle.");

  AST_NEW_SEL_ENC_B_TIMING: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_enc_write ##1 (encoder_phase_b_source_sel_q == `IPSM_CODE_PIN_HI)
    |=> encoder_phase_b_o == $past(remappable_pin_i[`IPSM_PIN_HI_INDEX]))
    else $error("Phase B pin write did not act the next cycle.");

  AST_UNMAPPED_READ_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_unmapped_read
    |=> reg_rdata_o == 16'h0000)
    else $error("Unmapped address read nonzero.");

endmodule // ipsm_input_route
`default_nettype wire

// ---- rtl/ipsm_regs.svh ----
/*
  Offsets, field positions, reset values and selector codes of the input routing multiplexer.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef IPSM_REGS_SVH
`define IPSM_REGS_SVH

`define IPSM_OFS_EXT_IRQ_ROUTE 8'h00
`define IPSM_OFS_ENC_ROUTE 8'h1C
`define IPSM_SEL_W 7
`define IPSM_HI_FIELD_LSB 8
`define IPSM_HI_FIELD_MSB 14
`define IPSM_LO_FIELD_LSB 0
`define IPSM_LO_FIELD_MSB 6
`define IPSM_SEL_RESET 7'h00
`define IPSM_CODE_GROUND 7'h00
`define IPSM_CODE_COMPARATOR_ONE 7'h01
`define IPSM_CODE_PIN_HI 7'h79
`define IPSM_PIN_HI_INDEX 121

`endif

// ---- rtl/ipsm_pkg.sv ----
/*
  Types shared by the input routing multiplexer files.
  Assumes the constants header is included where offsets are needed.
*/
package ipsm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ipsm_bus_req_t;

  typedef struct packed {
    logic ext_irq_one;
    logic enc_phase_a;
    logic enc_phase_b;
  } ipsm_routed_t;

endpackage

// ---- rtl/ipsm_source_mux.sv ----
/*
  One routing selector: maps a seven-bit code to a registered peripheral input.
  Assumes pin and comparator inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipsm_regs.svh"

module ipsm_source_mux #(
  parameter int NUM_PINS = 128
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [`IPSM_SEL_W-1:0] sel_i,
  input wire logic [NUM_PINS-1:0] remappable_pin_i,
  input wire logic comparator_one_output_i,
  output logic routed_o
);

  logic routed_d;
  logic routed_q;

  if (NUM_PINS < 2 ** `IPSM_SEL_W)
  begin : g_bad_pins
    $error("NUM_PINS must cover every seven-bit selector code.");
  end

  // Code zero ties the input to ground; the comparator takes code one; other codes pick a pin.
  always_comb
  begin
    if (sel_i == `IPSM_CODE_GROUND)
    begin
      routed_d = 1'b0;
    end
    else if (sel_i == `IPSM_CODE_COMPARATOR_ONE)
    begin
      routed_d = comparator_one_output_i;
    end
    else
    begin
      routed_d = remappable_pin_i[sel_i];
    end
  end

  // The routed value is registered so a selector change never glitches the peripheral.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      routed_q <= 1'b0;
    end
    else
    begin
      routed_q <= routed_d;
    end
  end

  assign routed_o = routed_q;

endmodule // ipsm_source_mux
`default_nettype wire

// ---- verif/ipsm_pin_model.sv ----
/*
  Model of the pins and the comparator that feed the routing block.
  Assumes the same mclk_i as the block; levels change after each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module ipsm_pin_model (
  input wire logic mclk_i,
  output logic [127:0] remappable_pin_o,
  output logic comparator_one_output_o
);
  // Pins rotate and invert each cycle and the comparator mixes in pin 5, so a stale or wrong source shows up.
  logic [127:0] pin_q = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic cmp_q = 1'b0;
  always @(posedge mclk_i)
  begin
    pin_q <= ~{pin_q[126:0], pin_q[127]};
    cmp_q <= ~cmp_q ^ pin_q[5];
  end
  assign remappable_pin_o = pin_q;
  assign comparator_one_output_o = cmp_q;
endmodule // ipsm_pin_model

`default_nettype wire

// ---- verif/tb.sv ----
/*
  Self-checking testbench of the input routing multiplexer.
  Assumes the pin model drives the pin and comparator inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipsm_regs.svh"

module tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  ipsm_pkg::ipsm_bus_req_t req = '0;
  logic [15:0] rdata;
  logic [127:0] pins;
  logic cmp, irq_o, a_o, b_o;
  int mismatches = 0;
  int checked = 0;

  always #20 mclk_i = ~mclk_i;

  ipsm_pin_model i_pins (.mclk_i(mclk_i), .remappable_pin_o(pins),
    .comparator_one_output_o(cmp));
  ipsm_input_route i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(req.addr),
    .reg_wdata_i(req.wdata), .reg_wr_i(req.wr), .reg_rd_i(req.rd), .reg_rdata_o(rdata),
    .remappable_pin_i(pins), .comparator_one_output_i(cmp),
    .external_interrupt_one_o(irq_o), .encoder_phase_a_o(a_o), .encoder_phase_b_o(b_o));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_route(input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error routed irq a b expected %b seen %b", exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    req.rd <= 1'b0;
    #1 chk("read data", exp, rdata);
  endtask

  function automatic logic src(input logic [6:0] c);
    return c == `IPSM_CODE_GROUND ? 1'b0 : c == `IPSM_CODE_COMPARATOR_ONE ? cmp : pins[c];
  endfunction

  // Checks four cycles of all three outputs, starting the cycle after a write.
  task automatic route(input logic [6:0] ci, input logic [6:0] ca, input logic [6:0] cb);
    logic [2:0] e;
    repeat (4)
    begin
      #1 e = {src(ci), src(ca), src(cb)};
      @(posedge mclk_i);
      #1 chk_route(e, {irq_o, a_o, b_o});
    end
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    route(7'h00, 7'h00, 7'h00);
    rd(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h0000);
    rd(`IPSM_OFS_ENC_ROUTE, 16'h0000);
    $display("test reset done");
    wr(`IPSM_OFS_EXT_IRQ_ROUTE, 16'hFFFF);
    rd(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h7F00);
    wr(`IPSM_OFS_ENC_ROUTE, 16'hFFFF);
    rd(`IPSM_OFS_ENC_ROUTE, 16'h7F7F);
    wr(8'h02, 16'hFFFF);
    rd(8'h02, 16'h0000);
    rd(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h7F00);
    $display("test access done");
    wr(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h7900);
    route(7'h79, 7'h7F, 7'h7F);
    wr(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h0100);
    route(7'h01, 7'h7F, 7'h7F);
    wr(`IPSM_OFS_ENC_ROUTE, 16'h7901);
    route(7'h01, 7'h01, 7'h79);
    wr(`IPSM_OFS_ENC_ROUTE, 16'h0179);
    route(7'h01, 7'h79, 7'h01);
    wr(`IPSM_OFS_EXT_IRQ_ROUTE, 16'h0000);
    route(7'h00, 7'h79, 7'h01);
    $display("test routing done");
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    route(7'h00, 7'h00, 7'h00);
    rd(`IPSM_OFS_ENC_ROUTE, 16'h0000);
    $display("test second reset done");
    test_done();
  end
endmodule // tb

`default_nettype wire
